// *** src/pxp_pkg.sv ***
// Constants, types and reset values for the 64-bit shared address/data port.
// Assumes one system clock domain and the bus feedback clock domain.
package pxp_pkg;
	localparam int AD_W = 64;
	localparam int CBE_W = 8;
	localparam int HALF_W = 32;
	localparam int CBE_HALF = 4;
	localparam int CNT_W = 6;
	localparam int CMD_W = 4;
	localparam int FIFO_DEPTH = 32;
	localparam int CMD_WR_BIT = 0;
	localparam logic [2:0] ABORT_CYCLES = 3'h5;
	localparam logic [AD_W-1:0] PARK_AD = 64'h0000_0000_0000_0000;
	localparam logic [CBE_W-1:0] PARK_CBE = 8'h00;
	localparam logic [CNT_W-1:0] REMAIN_ONE = 6'h01;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ADDR = 2'h1,
		ST_DATA = 2'h3,
		ST_TURN = 2'h2
	} pxp_state_t;

	typedef struct packed {
		logic [CMD_W-1:0] cmd;
		logic [AD_W-1:0] addr;
		logic [CBE_W-1:0] be_n;
		logic [CNT_W-1:0] nwords;
	} pxp_req_t;

	typedef struct packed {
		logic [AD_W-1:0] ad;
		logic [CBE_W-1:0] cbe;
		logic par;
		logic par64;
		logic frame_n;
		logic irdy_n;
		logic trdy_n;
		logic devsel_n;
		logic stop_n;
		logic gnt_n;
	} pxp_bus_in_t;

	typedef struct packed {
		logic [AD_W-1:0] ad;
		logic ad_oe;
		logic [CBE_W-1:0] cbe;
		logic cbe_oe;
		logic par;
		logic par_oe;
		logic par64;
		logic par64_oe;
		logic frame_n;
		logic frame_oe;
		logic irdy_n;
		logic irdy_oe;
	} pxp_bus_out_t;

	localparam pxp_bus_out_t BUS_OUT_RST = '{ad: '0, ad_oe: 1'b0, cbe: '0, cbe_oe: 1'b0, par: 1'b0,
		par_oe: 1'b0, par64: 1'b0, par64_oe: 1'b0, frame_n: 1'b1, frame_oe: 1'b0, irdy_n: 1'b1, irdy_oe: 1'b0};

	// Even parity over one 32-bit half and its four command lines
	function automatic logic par_even(input logic [HALF_W-1:0] ad, input logic [CBE_HALF-1:0] cbe);
		return ^{ad, cbe};
	endfunction
endpackage

// *** src/pxp_port.sv ***
// Shared address/data port: initiator engine, parity, parking, data FIFOs.
// Assumes bus pins are synchronous to bus_feedback_clock and the wire is resolved outside.
//
// Operation
// - Address on AD at first FRAME clock
// - Word moves when IRDY and TRDY asserted
// - Parked idle bus: drive lower AD
// - Parked idle bus: drive upper AD
// - Parked idle bus: drive all command lines
// - Command in address phase, byte enables after
// - Writer drives byte enables, else target
// - PAR is even parity, lower half
// - PAR64 is even parity, upper half
// - Initiating a write: parity lines tri-stated
// - Write target: parity after each phase
// - Read target: parity after address only
// - Parity released one cycle after AD
// - Parked idle bus: drive both parity lines
// - FRAME held, dropped on final phase
// - FRAME driven high one cycle before release
// - IRDY stays asserted until phase completes
// - Master abort without DEVSEL in five cycles
`timescale 1ns/100ps

module pxp_fifo #(
	parameter int W = 64,
	parameter int DEPTH = 32
) (
	input wire logic wr_clock,
	input wire logic wr_reset,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic rd_clock,
	input wire logic rd_reset,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wbin_ff, wgray_ff, rbin_ff, rgray_ff;
	logic [AW:0] nxt_wbin, nxt_wgray, nxt_rbin, nxt_rgray;
	logic [AW:0] rq_s_ff [3];
	logic [AW:0] wq_s_ff [3];
	logic [AW:0] rq_ff, wq_ff;
	logic full_ff, empty_ff;
	logic push, pop;

	assign push = in_valid & ~full_ff;
	assign pop = out_ready & ~empty_ff;
	assign in_ready = ~full_ff;
	assign out_valid = ~empty_ff;
	assign out_data = mem[rbin_ff[AW-1:0]];

	always_comb begin
		nxt_wbin = wbin_ff + {{AW{1'b0}}, push};
		nxt_wgray = (nxt_wbin >> 1) ^ nxt_wbin;
		nxt_rbin = rbin_ff + {{AW{1'b0}}, pop};
		nxt_rgray = (nxt_rbin >> 1) ^ nxt_rbin;
	end

	always_ff @(posedge wr_clock) begin
		if (push) begin
			mem[wbin_ff[AW-1:0]] <= in_data;
		end
	end

	// Write side: read pointer crosses gray coded
	always_ff @(posedge wr_clock) begin
		if (wr_reset) begin
			wbin_ff <= '0;
			wgray_ff <= '0;
			rq_s_ff <= '{default: '0};
			rq_ff <= '0;
			full_ff <= 1'b1;
		end else begin
			wbin_ff <= nxt_wbin;
			wgray_ff <= nxt_wgray;
			rq_s_ff[0] <= rgray_ff;
			rq_s_ff[1] <= rq_s_ff[0];
			rq_s_ff[2] <= rq_s_ff[1];
			if (rq_s_ff[1] == rq_s_ff[2]) begin
				rq_ff <= rq_s_ff[2];
			end
			full_ff <= (nxt_wgray == {~rq_ff[AW:AW-1], rq_ff[AW-2:0]});
		end
	end

	// Read side: write pointer crosses gray coded
	always_ff @(posedge rd_clock) begin
		if (rd_reset) begin
			rbin_ff <= '0;
			rgray_ff <= '0;
			wq_s_ff <= '{default: '0};
			wq_ff <= '0;
			empty_ff <= 1'b1;
		end else begin
			rbin_ff <= nxt_rbin;
			rgray_ff <= nxt_rgray;
			wq_s_ff[0] <= wgray_ff;
			wq_s_ff[1] <= wq_s_ff[0];
			wq_s_ff[2] <= wq_s_ff[1];
			if (wq_s_ff[1] == wq_s_ff[2]) begin
				wq_ff <= wq_s_ff[2];
			end
			empty_ff <= (nxt_rgray == wq_ff);
		end
	end
endmodule

module pxp_port
	import pxp_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic bus_feedback_clock,
	input wire logic req_valid,
	output logic req_ready,
	input wire pxp_req_t req,
	output logic done,
	output logic done_aborted,
	input wire logic wdata_valid,
	output logic wdata_ready,
	input wire logic [AD_W-1:0] wdata,
	output logic rdata_valid,
	input wire logic rdata_ready,
	output logic [AD_W-1:0] rdata,
	input wire pxp_bus_in_t bus_in,
	input wire logic tgt_claim,
	output pxp_bus_out_t bus_out
);
	typedef struct packed {
		logic busy;
		logic rdy;
		logic req_tgl;
		pxp_req_t req;
		logic [2:0] ack_s;
		logic ack_seen;
		logic done;
		logic aborted;
	} pxp_sys_t;

	typedef struct packed {
		pxp_state_t state;
		pxp_bus_out_t o;
		pxp_req_t req;
		logic pend;
		logic fin;
		logic [CNT_W-1:0] remain;
		logic [2:0] cnt;
		logic seen;
		logic aborted;
		logic ack_tgl;
		logic [2:0] req_s;
		logic req_seen;
		logic frame_prev;
		logic tgt_on;
		logic tgt_wr;
	} pxp_link_t;

	localparam pxp_sys_t SYS_RST = '{busy: 1'b0, rdy: 1'b1, req_tgl: 1'b0, req: '0, ack_s: '0,
		ack_seen: 1'b0, done: 1'b0, aborted: 1'b0};
	localparam pxp_link_t LINK_RST = '{state: ST_IDLE, o: BUS_OUT_RST, req: '0, pend: 1'b0, fin: 1'b0,
		remain: '0, cnt: '0, seen: 1'b0, aborted: 1'b0, ack_tgl: 1'b0, req_s: '0, req_seen: 1'b0,
		frame_prev: 1'b1, tgt_on: 1'b0, tgt_wr: 1'b0};

	pxp_sys_t s_ff, nxt_s;
	pxp_link_t l_ff, nxt_l;
	logic [2:0] lrst_s_ff;
	logic lrst_ff;
	logic wf_valid, wf_pop;
	logic [AD_W-1:0] wf_data;
	logic rf_ready, rf_push;
	logic ack_new, new_req, bus_idle, xfer, wr, room, tgt_addr, tgt_data, own_wr, park_ok;

	assign req_ready = s_ff.rdy;
	assign done = s_ff.done;
	assign done_aborted = s_ff.aborted;
	assign bus_out = l_ff.o;

	pxp_fifo #(.W(AD_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.wr_clock(clock),
		.wr_reset(reset),
		.in_data(wdata),
		.in_valid(wdata_valid),
		.in_ready(wdata_ready),
		.rd_clock(bus_feedback_clock),
		.rd_reset(lrst_ff),
		.out_data(wf_data),
		.out_valid(wf_valid),
		.out_ready(wf_pop)
	);

	pxp_fifo #(.W(AD_W), .DEPTH(FIFO_DEPTH)) u_rfifo (
		.wr_clock(bus_feedback_clock),
		.wr_reset(lrst_ff),
		.in_data(bus_in.ad),
		.in_valid(rf_push),
		.in_ready(rf_ready),
		.rd_clock(clock),
		.rd_reset(reset),
		.out_data(rdata),
		.out_valid(rdata_valid),
		.out_ready(rdata_ready)
	);

	// System side: request hold and completion handshake
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.ack_s = {s_ff.ack_s[1:0], l_ff.ack_tgl};
		ack_new = (s_ff.ack_s[1] == s_ff.ack_s[2]) & (s_ff.ack_s[2] != s_ff.ack_seen);
		if (ack_new) begin
			nxt_s.ack_seen = s_ff.ack_s[2];
			nxt_s.busy = 1'b0;
			nxt_s.done = 1'b1;
			nxt_s.aborted = l_ff.aborted;
		end else if (req_valid & ~s_ff.busy) begin
			nxt_s.req = req;
			nxt_s.busy = 1'b1;
			nxt_s.req_tgl = ~s_ff.req_tgl;
		end
		nxt_s.rdy = ~nxt_s.busy;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_ff <= SYS_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Reset carried into the bus clock domain
	always_ff @(posedge bus_feedback_clock) begin
		lrst_s_ff <= {lrst_s_ff[1:0], reset};
		if (lrst_s_ff[1] == lrst_s_ff[2]) begin
			lrst_ff <= lrst_s_ff[2];
		end
	end

	// Bus side engine
	always_comb begin
		nxt_l = l_ff;
		wr = l_ff.req.cmd[CMD_WR_BIT];
		bus_idle = bus_in.frame_n & bus_in.irdy_n;
		park_ok = ~bus_in.gnt_n & bus_idle & ~l_ff.tgt_on;
		xfer = (l_ff.state == ST_DATA) & ~l_ff.o.irdy_n & ~bus_in.irdy_n & ~bus_in.trdy_n;
		room = wr ? wf_valid : rf_ready;
		wf_pop = 1'b0;
		rf_push = xfer & ~wr;
		nxt_l.frame_prev = bus_in.frame_n;
		nxt_l.req_s = {l_ff.req_s[1:0], s_ff.req_tgl};
		new_req = (l_ff.req_s[1] == l_ff.req_s[2]) & (l_ff.req_s[2] != l_ff.req_seen);
		if (new_req) begin
			nxt_l.req_seen = l_ff.req_s[2];
			nxt_l.pend = 1'b1;
			nxt_l.req = s_ff.req;
		end

		// Target role tracking
		tgt_addr = l_ff.frame_prev & ~bus_in.frame_n & ~l_ff.o.frame_oe & tgt_claim;
		tgt_data = l_ff.tgt_on & ~bus_in.irdy_n & ~bus_in.trdy_n;
		if (tgt_addr) begin
			nxt_l.tgt_on = 1'b1;
			nxt_l.tgt_wr = bus_in.cbe[CMD_WR_BIT];
		end else if (tgt_data & bus_in.frame_n) begin
			nxt_l.tgt_on = 1'b0;
		end

		// Parity one clock behind the lines it covers
		own_wr = wr & ((l_ff.state == ST_ADDR) | (l_ff.state == ST_DATA));
		if (tgt_addr | (tgt_data & l_ff.tgt_wr)) begin
			nxt_l.o.par = par_even(bus_in.ad[HALF_W-1:0], bus_in.cbe[CBE_HALF-1:0]);
			nxt_l.o.par64 = par_even(bus_in.ad[AD_W-1:HALF_W], bus_in.cbe[CBE_W-1:CBE_HALF]);
			nxt_l.o.par_oe = 1'b1;
			nxt_l.o.par64_oe = 1'b1;
		end else begin
			nxt_l.o.par = par_even(l_ff.o.ad[HALF_W-1:0], l_ff.o.cbe[CBE_HALF-1:0]);
			nxt_l.o.par64 = par_even(l_ff.o.ad[AD_W-1:HALF_W], l_ff.o.cbe[CBE_W-1:CBE_HALF]);
			nxt_l.o.par_oe = l_ff.o.ad_oe & ~own_wr;
			nxt_l.o.par64_oe = l_ff.o.ad_oe & ~own_wr;
		end

		case (l_ff.state)
			ST_IDLE: begin
				nxt_l.o.frame_oe = 1'b0;
				nxt_l.o.irdy_oe = 1'b0;
				if (l_ff.fin) begin
					nxt_l.o.ad_oe = 1'b0;
					nxt_l.o.cbe_oe = 1'b0;
					if (l_ff.aborted & wr & (l_ff.remain != '0)) begin
						wf_pop = wf_valid;
						nxt_l.remain = l_ff.remain - CNT_W'(wf_valid);
					end else begin
						nxt_l.fin = 1'b0;
						nxt_l.ack_tgl = ~l_ff.ack_tgl;
					end
				end else if (l_ff.pend & park_ok) begin
					nxt_l.state = ST_ADDR;
					nxt_l.pend = 1'b0;
					nxt_l.aborted = 1'b0;
					nxt_l.o.ad = l_ff.req.addr;
					nxt_l.o.ad_oe = 1'b1;
					nxt_l.o.cbe = {l_ff.req.cmd, l_ff.req.cmd};
					nxt_l.o.cbe_oe = 1'b1;
					nxt_l.o.frame_n = 1'b0;
					nxt_l.o.frame_oe = 1'b1;
					nxt_l.o.irdy_n = 1'b1;
					nxt_l.o.irdy_oe = 1'b1;
					nxt_l.remain = (l_ff.req.nwords == '0) ? REMAIN_ONE : l_ff.req.nwords;
					nxt_l.cnt = '0;
					nxt_l.seen = 1'b0;
				end else if (park_ok) begin
					nxt_l.o.ad = PARK_AD;
					nxt_l.o.ad_oe = 1'b1;
					nxt_l.o.cbe = PARK_CBE;
					nxt_l.o.cbe_oe = 1'b1;
				end else begin
					nxt_l.o.ad_oe = 1'b0;
					nxt_l.o.cbe_oe = 1'b0;
				end
			end
			ST_ADDR: begin
				nxt_l.state = ST_DATA;
				nxt_l.o.ad_oe = wr;
				nxt_l.o.cbe = l_ff.req.be_n;
				nxt_l.o.cbe_oe = wr;
				nxt_l.seen = ~bus_in.devsel_n;
			end
			ST_DATA: begin
				if (~l_ff.seen) begin
					if (~bus_in.devsel_n) begin
						nxt_l.seen = 1'b1;
					end else begin
						nxt_l.cnt = l_ff.cnt + 3'h1;
					end
				end
				if (~l_ff.seen & bus_in.devsel_n & (l_ff.cnt + 3'h1 == ABORT_CYCLES)) begin
					nxt_l.state = ST_TURN;
					nxt_l.aborted = 1'b1;
					nxt_l.o.frame_n = 1'b1;
					nxt_l.o.irdy_n = 1'b1;
					nxt_l.o.ad_oe = 1'b0;
					nxt_l.o.cbe_oe = 1'b0;
				end else if (xfer) begin
					wf_pop = wr;
					nxt_l.remain = l_ff.remain - REMAIN_ONE;
					nxt_l.o.irdy_n = 1'b1;
					if (l_ff.remain == REMAIN_ONE) begin
						nxt_l.state = ST_TURN;
						nxt_l.o.ad_oe = 1'b0;
						nxt_l.o.cbe_oe = 1'b0;
						nxt_l.o.frame_oe = 1'b0;
					end
				end else if (l_ff.o.irdy_n & room) begin
					nxt_l.o.irdy_n = 1'b0;
					nxt_l.o.frame_n = (l_ff.remain == REMAIN_ONE);
					if (wr) begin
						nxt_l.o.ad = wf_data;
					end
				end
			end
			ST_TURN: begin
				nxt_l.o.ad_oe = 1'b0;
				nxt_l.o.cbe_oe = 1'b0;
				nxt_l.o.frame_n = 1'b1;
				nxt_l.o.frame_oe = l_ff.o.frame_oe & ~l_ff.o.frame_n;
				nxt_l.o.irdy_n = 1'b1;
				nxt_l.o.irdy_oe = l_ff.o.irdy_oe & ~l_ff.o.irdy_n;
				if (~nxt_l.o.frame_oe & ~nxt_l.o.irdy_oe) begin
					nxt_l.state = ST_IDLE;
					nxt_l.fin = 1'b1;
				end
			end
			default: begin
				nxt_l.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge bus_feedback_clock) begin
		if (lrst_ff) begin
			l_ff <= LINK_RST;
		end else begin
			l_ff <= nxt_l;
		end
	end
endmodule

// *** verification/pxp_port_properties.sv ***
// Assertions on the bus pins of the shared address/data port.
// Bound to pxp_port; bus_in is the resolved wire level.
`timescale 1ns/100ps
module pxp_chk
	import pxp_pkg::*;
(
	input wire logic reset,
	input wire logic bus_feedback_clock,
	input wire pxp_bus_in_t bus_in,
	input wire pxp_bus_out_t bus_out
);
	pxp_bus_out_t o;
	pxp_bus_in_t i;
	assign o = bus_out;
	assign i = bus_in;
	default clocking @(posedge bus_feedback_clock); endclocking
	default disable iff (reset);
	sequence s_adr;
		o.frame_oe && !o.frame_n && !$past(o.frame_oe && !o.frame_n);
	endsequence
	sequence s_wr;
		s_adr ##0 o.cbe[CMD_WR_BIT];
	endsequence
	property p_adr;
		s_adr |-> o.ad_oe && o.cbe_oe && o.irdy_oe && o.irdy_n && o.cbe[7:4] == o.cbe[3:0];
	endproperty
	a_adr: assert property (p_adr) else $error("address phase drive");
	property p_par;
		o.par_oe |-> o.par == ^{$past(i.ad[31:0]), $past(i.cbe[3:0])};
	endproperty
	a_par: assert property (p_par) else $error("par value");
	property p_par64;
		o.par64_oe |-> o.par64 == ^{$past(i.ad[63:32]), $past(i.cbe[7:4])};
	endproperty
	a_par64: assert property (p_par64) else $error("par64 value");
	property p_wr_par;
		s_wr |=> (!o.par_oe && !o.par64_oe) [*2];
	endproperty
	a_wr_par: assert property (p_wr_par) else $error("parity driven on own write");
	property p_rel;
		$fell(o.ad_oe) |=> !o.par_oe && !o.par64_oe;
	endproperty
	a_rel: assert property (p_rel) else $error("parity release late");
	property p_frame_rel;
		$fell(o.frame_oe) |-> $past(o.frame_n);
	endproperty
	a_frame_rel: assert property (p_frame_rel) else $error("frame released low");
	property p_irdy;
		o.irdy_oe && !o.irdy_n && i.trdy_n && !i.devsel_n |=> o.irdy_oe && !o.irdy_n;
	endproperty
	a_irdy: assert property (p_irdy) else $error("irdy dropped early");
	property p_abort;
		s_adr ##1 i.devsel_n [*5] |-> ##[1:4] !o.frame_oe;
	endproperty
	a_abort: assert property (p_abort) else $error("no master abort");
	property p_park;
		(!i.gnt_n && i.frame_n && i.irdy_n) [*8] |=> o.ad_oe && o.cbe_oe;
	endproperty
	a_park: assert property (p_park) else $error("parked bus floats");
	property p_park_par;
		(o.ad_oe && !o.frame_oe && !o.irdy_oe) [*2] |-> o.par_oe && o.par64_oe;
	endproperty
	a_park_par: assert property (p_park_par) else $error("parked parity floats");
endmodule

bind pxp_port pxp_chk u_chk (.reset, .bus_feedback_clock, .bus_in, .bus_out);

// *** verification/pxp_tgt.sv ***
// Far-side target model: claims, answers and resolves the wire.
// Assumes pull-ups on frame and irdy; lag 3 means nobody claims.
`timescale 1ns/100ps
module pxp_tgt
	import pxp_pkg::*;
(
	input wire logic bus_feedback_clock,
	input wire pxp_bus_out_t bus_out,
	input wire logic gnt_n,
	input wire logic [1:0] lag,
	input wire logic [AD_W-1:0] rd_word,
	input wire logic ext_frame_n,
	input wire logic ext_irdy_n,
	input wire logic [CBE_W-1:0] ext_cbe,
	output pxp_bus_in_t bus_in,
	output logic [AD_W-1:0] got_ad,
	output logic [AD_W-1:0] got_adr,
	output logic [CBE_W-1:0] got_be,
	output logic [CBE_W-1:0] got_cmd,
	output logic [7:0] got_n
);
	logic act = 1'b0;
	logic [2:0] age = 3'h0;
	logic [AD_W-1:0] lad = '0;
	logic [CBE_W-1:0] lcb = '0;
	pxp_bus_out_t o;
	assign o = bus_out;
	initial got_n = 8'h00;
	always_comb begin
		bus_in.frame_n = o.frame_oe ? o.frame_n : ext_frame_n;
		bus_in.irdy_n = o.irdy_oe ? o.irdy_n : ext_irdy_n;
		bus_in.ad = o.ad_oe ? o.ad : (act ? rd_word : ~lad);
		if (o.cbe_oe) begin
			bus_in.cbe = o.cbe;
		end else if (!ext_frame_n || !ext_irdy_n) begin
			bus_in.cbe = ext_cbe;
		end else begin
			bus_in.cbe = act ? 8'h00 : ~lcb;
		end
		bus_in.par = o.par_oe ? o.par : ~lad[0];
		bus_in.par64 = o.par64_oe ? o.par64 : ~lad[1];
		bus_in.devsel_n = !(act && age > 3'h0 && lag != 2'h3);
		bus_in.trdy_n = !(act && age > {1'b0, lag} && lag != 2'h3);
		bus_in.stop_n = 1'b1;
		bus_in.gnt_n = gnt_n;
	end
	always @(posedge bus_feedback_clock) begin
		lad <= bus_in.ad;
		lcb <= bus_in.cbe;
		if (!act && !bus_in.frame_n) begin
			act <= 1'b1;
			age <= 3'h0;
			got_adr <= bus_in.ad;
			got_cmd <= bus_in.cbe;
		end else if (act) begin
			age <= age + 3'(age != 3'h7);
			if (!bus_in.irdy_n && !bus_in.trdy_n) begin
				got_ad <= bus_in.ad;
				got_be <= bus_in.cbe;
				got_n <= got_n + 8'h01;
			end
			if (bus_in.frame_n && bus_in.irdy_n) begin
				act <= 1'b0;
			end
		end
	end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the shared address/data port.
// Assumes the far-side target model and the bound pin checker.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_top
	import pxp_pkg::*;
;
	logic clock = 0, bus_feedback_clock = 0, reset = 1;
	logic req_valid = 0, wdata_valid = 0, rdata_ready = 0, gnt_n = 0;
	logic req_ready, done, done_aborted, wdata_ready, rdata_valid;
	logic [1:0] lag = 2'h0;
	logic tgt_claim = 0, ext_frame_n = 1, ext_irdy_n = 1;
	logic [CBE_W-1:0] ext_cbe = '0;
	logic [AD_W-1:0] wdata = '0, rdata, got_ad, got_adr, rd_word = 64'h0123_4567_89AB_CDEF;
	logic [CBE_W-1:0] got_be, got_cmd;
	logic [7:0] got_n;
	pxp_req_t req = '0;
	pxp_bus_in_t bus_in;
	pxp_bus_out_t bus_out;
	int err_count = 0, checks_done = 0, cyc = 0;
	initial forever #5 clock = ~clock;
	initial begin
		#3.1;
		forever #24 bus_feedback_clock = ~bus_feedback_clock;
	end
	pxp_port uut (.clock, .reset, .bus_feedback_clock, .req_valid, .req_ready, .req, .done, .done_aborted,
		.wdata_valid, .wdata_ready, .wdata, .rdata_valid, .rdata_ready, .rdata, .bus_in, .tgt_claim, .bus_out);
	pxp_tgt far (.bus_feedback_clock, .bus_out, .gnt_n, .lag, .rd_word, .ext_frame_n, .ext_irdy_n, .ext_cbe,
		.bus_in, .got_ad, .got_adr, .got_be, .got_cmd, .got_n);
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic fill(input int n, input logic [AD_W-1:0] base);
		wdata_valid <= 1'b1;
		for (int j = 0; j < n; j++) begin
			wdata <= base + 64'(j);
			@(posedge clock);
			while (!wdata_ready) @(posedge clock);
		end
		wdata_valid <= 1'b0;
	endtask
	task automatic go(input logic [3:0] c, input logic [5:0] n, input logic [1:0] l, input logic ab);
		int k;
		k = 0;
		lag <= l;
		req <= '{cmd: c, addr: 64'h0000_00F0_1234_5670, be_n: 8'hA5, nwords: n};
		req_valid <= 1'b1;
		@(posedge clock);
		while (!req_ready) @(posedge clock);
		req_valid <= 1'b0;
		@(posedge clock);
		`CHK("busy", 1'b0, req_ready)
		while (done !== 1'b1 && k < 5000) begin
			@(posedge clock);
			k++;
		end
		`CHK("done", 1'b1, done)
		`CHK("ready", 1'b1, req_ready)
		`CHK("abort", ab, done_aborted)
		`CHK("addr", 64'h0000_00F0_1234_5670, got_adr)
		`CHK("cmd", {c, c}, got_cmd)
	endtask
	task automatic t_park();
		repeat (12) @(posedge bus_feedback_clock);
		#1;
		`CHK("park oe", 4'hF, {bus_out.ad_oe, bus_out.cbe_oe, bus_out.par_oe, bus_out.par64_oe})
		`CHK("park par", 2'h0, {bus_out.par, bus_out.par64})
		@(posedge clock);
	endtask
	task automatic t_burst();
		logic [7:0] n0;
		n0 = got_n;
		fill(FIFO_DEPTH, 64'h5A00_0000_0000_0000);
		repeat (2) @(posedge clock);
		`CHK("fifo full", 1'b0, wdata_ready)
		go(4'h7, 6'h20, 2'h2, 1'b0);
		`CHK("words", n0 + 8'h20, got_n)
		`CHK("last", 64'h5A00_0000_0000_001F, got_ad)
		`CHK("be", 8'hA5, got_be)
	endtask
	task automatic t_read();
		go(4'h6, 6'h02, 2'h0, 1'b0);
		`CHK("rd be", 8'h00, got_be)
		repeat (3) @(posedge clock);
		rdata_ready <= 1'b1;
		for (int j = 0; j < 2; j++) begin
			@(posedge clock);
			while (!rdata_valid) @(posedge clock);
			`CHK("rdata", rd_word, rdata)
		end
		rdata_ready <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("rd empty", 1'b0, rdata_valid)
	endtask
	task automatic t_abort();
		logic [7:0] n0;
		n0 = got_n;
		fill(3, 64'h0BAD_0000_0000_0000);
		go(4'h7, 6'h03, 2'h3, 1'b1);
		`CHK("no xfer", n0, got_n)
		fill(1, 64'h600D_0000_0000_0001);
		go(4'h3, 6'h01, 2'h0, 1'b0);
		`CHK("after abort", 64'h600D_0000_0000_0001, got_ad)
	endtask
	task automatic t_target(input logic [CBE_W-1:0] cmd);
		logic [1:0] p;
		gnt_n <= 1'b1;
		repeat (3) @(posedge bus_feedback_clock);
		ext_frame_n <= 1'b0;
		ext_cbe <= cmd;
		tgt_claim <= 1'b1;
		@(posedge bus_feedback_clock);
		p = {^{bus_in.ad[63:32], bus_in.cbe[7:4]}, ^{bus_in.ad[31:0], bus_in.cbe[3:0]}};
		tgt_claim <= 1'b0;
		ext_frame_n <= 1'b1;
		ext_irdy_n <= 1'b0;
		ext_cbe <= 8'h00;
		#1;
		`CHK("tgt adr par", {2'h3, p}, {bus_out.par64_oe, bus_out.par_oe, bus_out.par64, bus_out.par})
		do @(posedge bus_feedback_clock); while (bus_in.trdy_n);
		p = {^{bus_in.ad[63:32], bus_in.cbe[7:4]}, ^{bus_in.ad[31:0], bus_in.cbe[3:0]}};
		ext_irdy_n <= 1'b1;
		#1;
		`CHK("tgt dat oe", {2{cmd[CMD_WR_BIT]}}, {bus_out.par64_oe, bus_out.par_oe})
		if (cmd[CMD_WR_BIT])
			`CHK("tgt dat par", p, {bus_out.par64, bus_out.par})
		@(posedge bus_feedback_clock);
		gnt_n <= 1'b0;
		#1;
		`CHK("tgt rel", 2'h0, {bus_out.par64_oe, bus_out.par_oe})
		@(posedge clock);
	endtask
	initial begin
		repeat (16) @(posedge bus_feedback_clock);
		@(posedge clock);
		reset <= 1'b0;
		t_park();
		t_burst();
		t_read();
		t_abort();
		t_target(8'h77);
		t_target(8'h66);
		give_verdict();
	end
endmodule
